/* File: msp_pkg.sv */
// Constants and types for the mode select parameter list handler
package msp_pkg;
   // Page codes and fixed sizes
   localparam logic [5:0] PC_EAA    = 6'h1D;
   localparam logic [5:0] PC_LCD    = 6'h22;
   localparam logic [5:0] PC_CFG    = 6'h3D;
   localparam logic [7:0] EAA_LEN   = 8'h12;
   localparam logic [7:0] HDR_BYTES = 8'h04;
   localparam logic [4:0] EAA_FIELD_BYTES = 5'h10;
   localparam int         INIT_W    = 3;     // Initiator id width
   // Default element addresses
   localparam logic [15:0] DEF_MT_ADDR = 16'hFDE8;
   localparam logic [15:0] DEF_ST_ADDR = 16'h0000;
   localparam logic [15:0] DEF_IE_ADDR = 16'hFA00;
   localparam logic [15:0] DEF_DT_ADDR = 16'hF618;
   localparam logic [15:0] MT_COUNT    = 16'h0001;
   // Wishbone register byte offsets
   localparam logic [7:0] REG_ISTAT  = 8'h00;
   localparam logic [7:0] REG_IMASK  = 8'h04;
   localparam logic [7:0] REG_STATUS = 8'h08;
   localparam logic [7:0] REG_COUNTS = 8'h0C;
   localparam logic [7:0] REG_IECNT  = 8'h10;
   localparam logic [7:0] REG_CUR0   = 8'h14;
   localparam logic [7:0] REG_CUR3   = 8'h20;
   // Interrupt bit positions
   localparam int IRQ_DONE = 0;
   localparam int IRQ_ERR  = 1;
   localparam int IRQ_UA   = 2;
   localparam int IRQ_W    = 3;
   localparam logic [IRQ_W-1:0] IMASK_RST = 3'h0;

   // Element address page contents, first field in the top bits
   typedef struct packed {
      logic [15:0] mt_addr;
      logic [15:0] mt_cnt;
      logic [15:0] st_addr;
      logic [15:0] st_cnt;
      logic [15:0] ie_addr;
      logic [15:0] ie_cnt;
      logic [15:0] dt_addr;
      logic [15:0] dt_cnt;
   } msp_eaa_t;

   // Mode select command descriptor fields
   typedef struct packed {
      logic              page_format_flag;
      logic              save_pages_flag;
      logic [7:0]        len;
      logic [INIT_W-1:0] init;
   } msp_cmd_t;

   // Completion codes
   typedef enum logic [2:0] {
      ERR_NONE, ERR_FORMAT, ERR_HDR, ERR_PAGE, ERR_DUP, ERR_LEN, ERR_FIELD
   } msp_err_t;
endpackage : msp_pkg

/* File: msp_top.sv */
// Mode select parameter list parser with settings store and Wishbone slave
module msp_top #(
   parameter logic [15:0] P_ST_CNT   = 16'h0010, // Reported storage count
   parameter logic [15:0] P_IE_CNT   = 16'h0000, // Reported port count
   parameter logic [15:0] P_DT_CNT   = 16'h0002, // Reported drive count
   parameter logic [5:0]  P_EXT_CODE = 6'h3E     // External data page code
) (
   input  wire logic                          i_sys_clk,
   input  wire logic                          i_sys_rst,
   input  wire logic                          i_nv_init,
   input  wire logic                          i_cmd_start,
   input  wire msp_pkg::msp_cmd_t             i_cmd,
   input  wire logic                          i_dout_valid,
   input  wire logic [7:0]                    i_dout_byte,
   output logic                               o_dout_ready,
   output logic                               o_busy,
   output logic                               o_done,
   output msp_pkg::msp_err_t                  o_err,
   output logic                               o_nv_write,
   output msp_pkg::msp_eaa_t                  o_cur,
   input  wire logic                          i_req_valid,
   input  wire logic [msp_pkg::INIT_W-1:0]    i_req_init,
   output logic                               o_ua_hit,
   input  wire logic                          i_wb_cyc,
   input  wire logic                          i_wb_stb,
   input  wire logic                          i_wb_we,
   input  wire logic [7:0]                    i_wb_adr,
   input  wire logic [31:0]                   i_wb_dat,
   input  wire logic [3:0]                    i_wb_sel,
   output logic [31:0]                        o_wb_dat,
   output logic                               o_wb_ack,
   output logic                               o_irq
);
   localparam int NI = 1 << msp_pkg::INIT_W;
   localparam int IRQ_W_L = msp_pkg::IRQ_W; // Event bit count
   // Factory settings built from fixed starts and reported counts
   localparam msp_pkg::msp_eaa_t DEF_EAA = '{
      mt_addr: msp_pkg::DEF_MT_ADDR, mt_cnt: msp_pkg::MT_COUNT,
      st_addr: msp_pkg::DEF_ST_ADDR, st_cnt: P_ST_CNT,
      ie_addr: msp_pkg::DEF_IE_ADDR, ie_cnt: P_IE_CNT,
      dt_addr: msp_pkg::DEF_DT_ADDR, dt_cnt: P_DT_CNT};

   typedef enum logic [2:0] {S_IDLE, S_HDR, S_CODE, S_PLEN, S_BODY, S_CHECK} msp_st_t;

   msp_st_t             st_r;        // Parser state
   msp_pkg::msp_cmd_t   cmd_r;       // Latched command
   msp_pkg::msp_err_t   err_r;       // First error seen
   msp_pkg::msp_eaa_t   stage_r;     // Incoming page fields
   msp_pkg::msp_eaa_t   cur_r;       // Current settings
   msp_pkg::msp_eaa_t   saved_r;     // Non-volatile settings
   logic [7:0]          rem_r;       // Bytes still to arrive
   logic [7:0]          pcnt_r;      // Page body bytes left
   logic [4:0]          bidx_r;      // Index into page body
   logic [1:0]          hcnt_r;      // Header byte index
   logic [3:0]          seen_r;      // Pages met in this list
   logic                is_eaa_r;    // Current page is element page
   logic                ready_r;     // Byte stream ready
   logic                done_r;      // Completion pulse
   msp_pkg::msp_err_t   last_err_r;  // Completion code
   logic                nv_wr_r;     // Saved storage written pulse
   logic [NI-1:0]       ua_pend_r;   // Pending unit attention per initiator
   logic                ua_hit_r;    // Unit attention reported
   logic [15:0]         rep_st_r;    // Reported storage count
   logic [15:0]         rep_ie_r;    // Reported port count
   logic [15:0]         rep_dt_r;    // Reported drive count
   logic [IRQ_W_L-1:0]  istat_r;     // Sticky event bits
   logic [IRQ_W_L-1:0]  imask_r;     // Event enables
   logic                irq_r;       // Interrupt level
   logic                ack_r;       // Wishbone acknowledge
   logic [31:0]         rdat_r;      // Wishbone read data
   logic                busy_r;      // Command in progress

   // Page code to slot: 0 element, 1 display, 2 config, 3 external, 4 unknown
   function automatic logic [2:0] page_slot(input logic [7:0] b);
      logic [2:0] s;
      s = 3'h4;
      if (b[7:6] == 2'h0)
      begin
         if (b[5:0] == msp_pkg::PC_EAA) s = 3'h0;
         else if (b[5:0] == msp_pkg::PC_LCD) s = 3'h1;
         else if (b[5:0] == msp_pkg::PC_CFG) s = 3'h2;
         else if (b[5:0] == P_EXT_CODE) s = 3'h3;
      end
      return s;
   endfunction : page_slot

   // Keep the earliest error so the host sees the first fault
   function automatic msp_pkg::msp_err_t keep_err(input msp_pkg::msp_err_t o,
                                                  input msp_pkg::msp_err_t n);
      return (o != msp_pkg::ERR_NONE) ? o : n;
   endfunction : keep_err

   logic       take;      // Byte accepted this cycle
   logic       last;      // Accepted byte is the final one
   logic [2:0] slot;      // Decoded page slot
   logic       eaa_seen;  // Element page received
   logic       fields_ok; // Element counts valid
   msp_pkg::msp_err_t fin_err; // Final verdict
   logic       commit;    // Apply element settings
   logic       ua_set;    // Settings really changed
   assign take      = i_dout_valid & ready_r;
   assign last      = (rem_r == 8'h01);
   assign slot      = page_slot(i_dout_byte);
   assign eaa_seen  = seen_r[0];
   assign fields_ok = (stage_r.mt_cnt == msp_pkg::MT_COUNT)
                    & (stage_r.st_cnt == rep_st_r)
                    & (stage_r.ie_cnt == rep_ie_r)
                    & (stage_r.dt_cnt == rep_dt_r);
   assign fin_err   = keep_err(err_r, (eaa_seen && !fields_ok) ? msp_pkg::ERR_FIELD
                                                               : msp_pkg::ERR_NONE);
   assign commit    = (st_r == S_CHECK) && (fin_err == msp_pkg::ERR_NONE);
   assign ua_set    = commit && eaa_seen && (stage_r != cur_r);

   // Parser walks header, page codes, lengths and bodies
   always_ff @(posedge i_sys_clk)
   begin
      if (i_sys_rst)
      begin
         st_r       <= S_IDLE;
         cmd_r      <= '0;
         err_r      <= msp_pkg::ERR_NONE;
         stage_r    <= '0;
         rem_r      <= 8'h00;
         pcnt_r     <= 8'h00;
         bidx_r     <= 5'h00;
         hcnt_r     <= 2'h0;
         seen_r     <= 4'h0;
         is_eaa_r   <= 1'b0;
         ready_r    <= 1'b0;
         done_r     <= 1'b0;
         last_err_r <= msp_pkg::ERR_NONE;
      end
      else
      begin
         done_r <= 1'b0;
         if (take)
            rem_r <= rem_r - 8'h01;
         unique case (st_r)
            S_IDLE:
               if (i_cmd_start)
               begin
                  cmd_r    <= i_cmd;
                  rem_r    <= i_cmd.len;
                  hcnt_r   <= 2'h0;
                  seen_r   <= 4'h0;
                  // Only the structured page format is supported
                  err_r    <= i_cmd.page_format_flag ? msp_pkg::ERR_NONE : msp_pkg::ERR_FORMAT;
                  if (i_cmd.len != 8'h00 && i_cmd.len < msp_pkg::HDR_BYTES)
                     err_r <= keep_err(i_cmd.page_format_flag ? msp_pkg::ERR_NONE : msp_pkg::ERR_FORMAT,
                                       msp_pkg::ERR_LEN);
                  // Zero length moves no data at all
                  ready_r  <= (i_cmd.len != 8'h00);
                  st_r     <= (i_cmd.len != 8'h00) ? S_HDR : S_CHECK;
               end
            S_HDR:
               if (take)
               begin
                  // Header must be all zero
                  if (i_dout_byte != 8'h00)
                     err_r <= keep_err(err_r, msp_pkg::ERR_HDR);
                  hcnt_r <= hcnt_r + 2'h1;
                  if (hcnt_r == 2'h3)
                     st_r <= S_CODE;
               end
            S_CODE:
               if (take)
               begin
                  is_eaa_r <= (slot == 3'h0);
                  if (slot == 3'h4)
                     err_r <= keep_err(err_r, msp_pkg::ERR_PAGE);
                  else if (seen_r[slot[1:0]])
                     err_r <= keep_err(err_r, msp_pkg::ERR_DUP);
                  else if (last)
                     err_r <= keep_err(err_r, msp_pkg::ERR_LEN);
                  if (slot != 3'h4)
                     seen_r[slot[1:0]] <= 1'b1;
                  st_r <= S_PLEN;
               end
            S_PLEN:
               if (take)
               begin
                  pcnt_r <= i_dout_byte;
                  bidx_r <= 5'h00;
                  if (is_eaa_r && i_dout_byte != msp_pkg::EAA_LEN)
                     err_r <= keep_err(err_r, msp_pkg::ERR_FIELD);
                  else if (i_dout_byte > rem_r - 8'h01)
                     err_r <= keep_err(err_r, msp_pkg::ERR_LEN);
                  st_r <= (i_dout_byte == 8'h00) ? S_CODE : S_BODY;
               end
            S_BODY:
               if (take)
               begin
                  pcnt_r <= pcnt_r - 8'h01;
                  bidx_r <= bidx_r + 5'h01;
                  // Fields arrive most significant byte first
                  if (is_eaa_r && bidx_r < msp_pkg::EAA_FIELD_BYTES)
                     stage_r <= msp_pkg::msp_eaa_t'({stage_r[119:0], i_dout_byte});
                  else if (is_eaa_r && i_dout_byte != 8'h00)
                     err_r <= keep_err(err_r, msp_pkg::ERR_FIELD);
                  if (pcnt_r == 8'h01)
                     st_r <= S_CODE;
               end
            S_CHECK:
            begin
               done_r     <= 1'b1;
               last_err_r <= fin_err;
               st_r       <= S_IDLE;
            end
         endcase
         // Final byte ends the list whatever the parse position
         if (take && last)
         begin
            ready_r <= 1'b0;
            st_r    <= S_CHECK;
         end
      end
   end

   // Busy flag kept in its own flop so the output is registered
   always_ff @(posedge i_sys_clk)
   begin
      if (i_sys_rst)
         busy_r <= 1'b0;
      else if (st_r == S_IDLE && i_cmd_start)
         busy_r <= 1'b1; // Set on the start edge
      else if (st_r == S_CHECK)
         busy_r <= 1'b0; // Cleared as the verdict is issued
   end

   // Settings store: reset reloads, accepted command applies
   always_ff @(posedge i_sys_clk)
   begin
      nv_wr_r <= 1'b0;
      if (i_nv_init)
         saved_r <= DEF_EAA;
      if (i_sys_rst)
         cur_r <= saved_r;
      else if (commit)
      begin
         // Element starts take effect now; later elements count upward
         if (eaa_seen)
            cur_r <= stage_r;
         // Config and external pages may persist without the save flag
         if (cmd_r.save_pages_flag || seen_r[2] || seen_r[3])
            nv_wr_r <= 1'b1;
         if (cmd_r.save_pages_flag && eaa_seen)
            saved_r <= stage_r;
      end
   end

   // Unit attention bookkeeping; a new set beats a same-cycle report
   always_ff @(posedge i_sys_clk)
   begin
      if (i_sys_rst)
      begin
         ua_pend_r <= '0;
         ua_hit_r  <= 1'b0;
      end
      else
      begin
         ua_hit_r  <= i_req_valid && ua_pend_r[i_req_init];
         ua_pend_r <= (ua_set ? ~(NI'(1) << cmd_r.init) : '0)
                    | (ua_pend_r & ~(i_req_valid ? NI'(1) << i_req_init : '0));
      end
   end

   logic wb_req; // New request this cycle
   logic wb_wr;  // Write lands on the acknowledged edge only
   logic [IRQ_W_L-1:0] ev; // Event pulses
   assign wb_req = i_wb_cyc & i_wb_stb & ~ack_r;
   assign wb_wr  = i_wb_cyc & i_wb_stb & i_wb_we & ack_r;
   assign ev     = {ua_set, commit ? 1'b0 : (st_r == S_CHECK), st_r == S_CHECK};

   // Interrupt status, write one to clear, event wins
   always_ff @(posedge i_sys_clk)
   begin
      if (i_sys_rst)
      begin
         istat_r <= '0;
         imask_r <= msp_pkg::IMASK_RST;
         irq_r   <= 1'b0;
      end
      else
      begin
         istat_r <= ev | (istat_r & ~((wb_wr && i_wb_adr == msp_pkg::REG_ISTAT && i_wb_sel[0])
                                      ? i_wb_dat[IRQ_W_L-1:0] : '0));
         if (wb_wr && i_wb_adr == msp_pkg::REG_IMASK && i_wb_sel[0])
            imask_r <= i_wb_dat[IRQ_W_L-1:0];
         irq_r <= |(istat_r & imask_r);
      end
   end

   // Reported counts, normally loaded by firmware from library layout
   always_ff @(posedge i_sys_clk)
   begin
      if (i_sys_rst)
      begin
         rep_st_r <= P_ST_CNT;
         rep_ie_r <= P_IE_CNT;
         rep_dt_r <= P_DT_CNT;
      end
      else if (wb_wr)
      begin
         if (i_wb_adr == msp_pkg::REG_COUNTS && i_wb_sel[1:0] == 2'h3)
            rep_st_r <= i_wb_dat[15:0];
         if (i_wb_adr == msp_pkg::REG_COUNTS && i_wb_sel[3:2] == 2'h3)
            rep_dt_r <= i_wb_dat[31:16];
         if (i_wb_adr == msp_pkg::REG_IECNT && i_wb_sel[1:0] == 2'h3)
            rep_ie_r <= i_wb_dat[15:0];
      end
   end

   // Wishbone slave: one wait state, unmapped reads give zero
   always_ff @(posedge i_sys_clk)
   begin
      if (i_sys_rst)
      begin
         ack_r  <= 1'b0;
         rdat_r <= 32'h0000_0000;
      end
      else
      begin
         ack_r  <= wb_req;
         rdat_r <= 32'h0000_0000;
         if (wb_req && !i_wb_we)
         begin
            if (i_wb_adr == msp_pkg::REG_ISTAT)
               rdat_r <= {29'h0, istat_r};
            else if (i_wb_adr == msp_pkg::REG_IMASK)
               rdat_r <= {29'h0, imask_r};
            else if (i_wb_adr == msp_pkg::REG_STATUS)
               rdat_r <= {28'h0, st_r != S_IDLE, last_err_r};
            else if (i_wb_adr == msp_pkg::REG_COUNTS)
               rdat_r <= {rep_dt_r, rep_st_r};
            else if (i_wb_adr == msp_pkg::REG_IECNT)
               rdat_r <= {16'h0, rep_ie_r};
            else if (i_wb_adr >= msp_pkg::REG_CUR0 && i_wb_adr <= msp_pkg::REG_CUR3
                     && i_wb_adr[1:0] == 2'h0)
               rdat_r <= cur_r[127 - 32 * int'((i_wb_adr - msp_pkg::REG_CUR0) >> 2) -: 32];
         end
      end
   end

   // Registered outputs
   assign o_dout_ready = ready_r;
   assign o_busy       = busy_r;
   assign o_done       = done_r;
   assign o_err        = last_err_r;
   assign o_nv_write   = nv_wr_r;
   assign o_cur        = cur_r;
   assign o_ua_hit     = ua_hit_r;
   assign o_wb_dat     = rdat_r;
   assign o_wb_ack     = ack_r;
   assign o_irq        = irq_r;

   default clocking dc @(posedge i_sys_clk); endclocking
   default disable iff (i_sys_rst);

   a_zero_len_done: assert property ((st_r == S_IDLE && i_cmd_start && i_cmd.len == 8'h00)
      |=> !o_dout_ready ##1 o_done) else $error("zero length list moved data");
   a_format_refused: assert property (o_done && !cmd_r.page_format_flag
      |-> o_err == msp_pkg::ERR_FORMAT) else $error("page format zero accepted");
   a_err_no_change: assert property (o_done && o_err != msp_pkg::ERR_NONE
      |-> cur_r == $past(cur_r) && saved_r == $past(saved_r))
      else $error("failed command changed settings");
   a_ok_applied: assert property (o_done && o_err == msp_pkg::ERR_NONE && eaa_seen
      |-> cur_r == stage_r) else $error("accepted page not applied");
   a_save_flag: assert property (o_done && o_err == msp_pkg::ERR_NONE && eaa_seen
      |-> (cmd_r.save_pages_flag ? saved_r == stage_r : saved_r == $past(saved_r)))
      else $error("saved settings mismatch save flag");
   a_reset_reload: assert property (disable iff (1'b0) i_sys_rst && !i_nv_init
      |=> cur_r == $past(saved_r)) else $error("reset did not reload");
   a_mt_count: assert property (o_done && eaa_seen && stage_r.mt_cnt != msp_pkg::MT_COUNT
      |-> o_err != msp_pkg::ERR_NONE) else $error("bad transport count accepted");
   a_ua_others: assert property (ua_set
      |=> &(ua_pend_r | (NI'(1) << $past(cmd_r.init)))) else $error("unit attention not raised");
   a_ua_report: assert property (i_req_valid && ua_pend_r[i_req_init]
      |=> o_ua_hit) else $error("pending unit attention not reported");
endmodule : msp_top

/* File: msp_host_model.sv */
// Initiator model: sends one command and streams its parameter list
module msp_host_model
(
   input  wire logic         i_clk,   // System clock
   input  wire logic         i_ready, // Handler wants a byte
   output logic              o_start, // Command start pulse
   output msp_pkg::msp_cmd_t o_cmd,   // Command fields
   output logic              o_valid, // Byte valid
   output logic [7:0]        o_byte   // Byte lane
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] lst [0:43]; // List bytes, filled by the bench MSB first

   // Idle values at time zero
   initial
   begin
      o_start = 1'b0;
      o_cmd   = '0;
      o_valid = 1'b0;
      o_byte  = 8'h00;
   end

   // One command; the bench only calls this after done of the previous one
   task automatic run(input msp_pkg::msp_cmd_t c);
      o_start <= 1'b1;
      o_cmd   <= c; // Flag and length as given
      @(posedge i_clk);
      o_start <= 1'b0;
      // Exactly len bytes, each held until taken
      for (int i = 0; i < c.len; i++)
      begin
         o_valid <= 1'b1;
         o_byte  <= lst[i];
         do @(posedge i_clk); while (i_ready !== 1'b1);
      end
      // Released lane shows junk, not the last byte
      o_valid <= 1'b0;
      o_byte  <= ~o_byte;
   endtask : run
endmodule : msp_host_model

/* File: mode_select_param_handler_tb.sv */
// Self-checking bench for the mode select parameter handler
module mode_select_param_handler_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst, nv_init, req_v, cyc, stb, we, ack, irq, done, nv_w, rdy, h_start, h_v, ua, busy;
   logic [2:0]  req_i;
   logic [7:0]  adr, h_byte;
   logic [31:0] wdat, rdat, q;
   msp_pkg::msp_cmd_t h_cmd;
   msp_pkg::msp_err_t err, got_err;
   msp_pkg::msp_eaa_t cur, e1, e2;
   logic        got_nv;
   int          err_count, cmp_count, cyc_count;

   msp_top dut_u (.i_sys_clk(clk), .i_sys_rst(rst), .i_nv_init(nv_init), .i_cmd_start(h_start),
      .i_cmd(h_cmd), .i_dout_valid(h_v), .i_dout_byte(h_byte), .o_dout_ready(rdy), .o_busy(busy),
      .o_done(done), .o_err(err), .o_nv_write(nv_w), .o_cur(cur), .i_req_valid(req_v),
      .i_req_init(req_i), .o_ua_hit(ua), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
      .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(4'hF), .o_wb_dat(rdat), .o_wb_ack(ack), .o_irq(irq));
   msp_host_model host_u (.i_clk(clk), .i_ready(rdy), .o_start(h_start), .o_cmd(h_cmd),
      .o_valid(h_v), .o_byte(h_byte));

   // 100 MHz clock
   always #5 clk = ~clk;

   // Hang guard, far above the few hundred cycles needed
   always @(posedge clk)
   begin
      cyc_count++;
      if (cyc_count == 20000)
      begin
         err_count++;
         end_of_test();
      end
   end

   task automatic chk(input string nm, input logic [127:0] seen, input logic [127:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         err_count++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   // Classic Wishbone cycle, held until ack is sampled
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
      // Only the bench timeout ends this wait
      do @(posedge clk); while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
      @(posedge clk);
   endtask : wb

   // Header plus element page, repeated at byte 24 for the duplicate case
   task automatic fill(input msp_pkg::msp_eaa_t e);
      for (int b = 0; b < 4; b++) host_u.lst[b] = 8'h00;
      for (int p = 4; p < 44; p += 20)
      begin
         host_u.lst[p]    = {2'b00, msp_pkg::PC_EAA};
         host_u.lst[p+1]  = msp_pkg::EAA_LEN;
         for (int k = 0; k < 16; k++) host_u.lst[p+2+k] = e[127-8*k -: 8];
         host_u.lst[p+18] = 8'h00;
         host_u.lst[p+19] = 8'h00;
      end
   endtask : fill

   task automatic run(input logic fmt, input logic sav, input logic [7:0] len, input logic [2:0] ini);
      int n;
      n = 0;
      host_u.run('{page_format_flag: fmt, save_pages_flag: sav, len: len, init: ini});
      @(posedge clk);
      chk("busy", busy, 1'b1);
      do begin @(posedge clk); n++; end while (done !== 1'b1 && n < 200);
      got_err = err;
      got_nv  = nv_w;
      chk("done", done, 1'b1);
      chk("busy", busy, 1'b0);
   endtask : run

   // Request from one initiator, unit attention expected or not
   task automatic req(input logic [2:0] ini, input logic exp);
      req_v <= 1'b1; req_i <= ini;
      @(posedge clk);
      req_v <= 1'b0;
      @(posedge clk);
      chk("ua_hit", ua, exp);
   endtask : req

   task automatic do_reset();
      rst <= 1'b1;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
   endtask : do_reset

   task automatic t_empty();
      run(1'b1, 1'b0, 8'h00, 3'h0);
      chk("err", got_err, msp_pkg::ERR_NONE);
      chk("nv", got_nv, 1'b0);
      run(1'b0, 1'b0, 8'h00, 3'h0);
      chk("err", got_err, msp_pkg::ERR_FORMAT);
      $display("test empty and flag done");
   endtask : t_empty

   // Volatile change, unit attention, then reset restores saved values
   task automatic t_volatile();
      fill(e1);
      run(1'b1, 1'b0, 8'h18, 3'h0);
      chk("err", got_err, msp_pkg::ERR_NONE);
      chk("nv", got_nv, 1'b0);
      chk("cur", cur, e1);
      req(3'h0, 1'b0);
      req(3'h1, 1'b1);
      req(3'h1, 1'b0);
      do_reset();
      chk("dt_addr", cur.dt_addr, 16'd63000);
      $display("test volatile done");
   endtask : t_volatile

   task automatic t_saved();
      run(1'b1, 1'b1, 8'h18, 3'h2);
      chk("nv", got_nv, 1'b1);
      do_reset();
      chk("cur", cur, e1);
      $display("test saved done");
   endtask : t_saved

   // Bad lists: one poked byte, a repeated page or a short length, nothing applied
   task automatic t_errors();
      logic [7:0] ix [8] = '{8'h01, 8'h04, 8'h05, 8'h09, 8'h0D, 8'h17, 8'h00, 8'h00};
      logic [7:0] vl [8] = '{8'h01, 8'h5D, 8'h11, 8'h02, 8'h11, 8'h01, 8'h00, 8'h00};
      logic [7:0] ln [8] = '{8'h18, 8'h18, 8'h18, 8'h18, 8'h18, 8'h18, 8'h2C, 8'h14};
      msp_pkg::msp_err_t ex [8] = '{msp_pkg::ERR_HDR, msp_pkg::ERR_PAGE, msp_pkg::ERR_FIELD,
         msp_pkg::ERR_FIELD, msp_pkg::ERR_FIELD, msp_pkg::ERR_FIELD, msp_pkg::ERR_DUP, msp_pkg::ERR_LEN};
      for (int i = 0; i < 8; i++)
      begin
         fill(e2);
         host_u.lst[ix[i]] = vl[i];
         run(1'b1, 1'b1, ln[i], 3'h0);
         chk("err", got_err, ex[i]);
         chk("nv", got_nv, 1'b0);
         chk("cur", cur, e1);
      end
      $display("test errors done");
   endtask : t_errors

   // Config page alone persists even with the save flag clear
   task automatic t_config();
      host_u.lst[4] = {2'b00, msp_pkg::PC_CFG};
      host_u.lst[5] = 8'h00;
      run(1'b1, 1'b0, 8'h06, 3'h1);
      chk("err", got_err, msp_pkg::ERR_NONE);
      chk("nv", got_nv, 1'b1);
      chk("cur", cur, e1);
      $display("test config done");
   endtask : t_config

   // Registers: counts, current view, unmapped place, interrupt
   task automatic t_regs();
      wb(1'b0, msp_pkg::REG_COUNTS, 32'h0);
      chk("counts", q, 32'h0002_0010);
      wb(1'b0, msp_pkg::REG_CUR3, 32'h0);
      chk("cur3", q, {e1.dt_addr, e1.dt_cnt});
      wb(1'b0, 8'hFC, 32'h0);
      chk("unmapped", q, 32'h0);
      wb(1'b1, msp_pkg::REG_IMASK, 32'h0000_0001);
      @(posedge clk);
      chk("irq", irq, 1'b1);
      wb(1'b1, msp_pkg::REG_ISTAT, 32'h0000_0007);
      @(posedge clk);
      chk("irq", irq, 1'b0);
      wb(1'b0, msp_pkg::REG_ISTAT, 32'h0);
      chk("istat", q, 32'h0);
      $display("test registers done");
   endtask : t_regs

   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : end_of_test

   initial
   begin
      clk = 1'b0; rst = 1'b1; nv_init = 1'b1; req_v = 1'b0; req_i = 3'h0;
      cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; wdat = 32'h0;
      err_count = 0; cmp_count = 0; cyc_count = 0;
      e1 = '{16'h0100, 16'h0001, 16'h0020, 16'h0010, 16'h0200, 16'h0000, 16'h0300, 16'h0002};
      e2 = e1;
      e2.mt_addr = 16'h0400;
      repeat (5) @(posedge clk);
      nv_init <= 1'b0;
      rst <= 1'b0;
      @(posedge clk);
      chk("st_addr", cur.st_addr, 16'h0000);
      chk("dt_addr", cur.dt_addr, 16'd63000);
      t_empty();
      t_volatile();
      t_saved();
      t_errors();
      t_config();
      t_regs();
      end_of_test();
   end
endmodule : mode_select_param_handler_tb
